// [core/edge_ram_host.sv]
//==========================================================================
`timescale 1ns/1ps
`default_nettype none
`include "edge_ram_consts.svh"

module edge_ram_host #(
    parameter bit SLOW_GRADE = 1'b0,
    parameter bit VARIANT_HIGH = 1'b1
) (
    // clock and reset
    input  wire logic                   i_clock,
    input  wire logic                   i_reset_n,
    // command port
    input  wire logic                   i_req_valid,
    input  wire edge_ram_pkg::ram_req_t i_req,
    output logic                        o_req_ready,
    output logic                        o_rsp_valid,
    output logic                        o_rsp_data,
    // memory pins
    output var edge_ram_pkg::ram_pins_t o_pins,
    output logic                        o_variant,
    input  wire logic                   i_ram_q
);

    //======================================================================
    // timing counts
    localparam int LOW_CYC   = SLOW_GRADE ? `NS_TO_CYC_UP(`SLOW_LOW_NS)
                                          : `NS_TO_CYC_UP(`FAST_LOW_NS);
    localparam int HIGH_RAW  = SLOW_GRADE ? `NS_TO_CYC_UP(`SLOW_HIGH_NS)
                                          : `NS_TO_CYC_UP(`FAST_HIGH_NS);
    localparam int CYC_CYC   = SLOW_GRADE ? `NS_TO_CYC_UP(`SLOW_CYCLE_NS)
                                          : `NS_TO_CYC_UP(`FAST_CYCLE_NS);
    // high phase stretched so low plus high meets the full cycle
    localparam int HIGH_CYC  = (LOW_CYC + HIGH_RAW >= CYC_CYC) ? HIGH_RAW
                                                               : CYC_CYC - LOW_CYC;
    localparam int ACC_CYC   = `NS_TO_CYC_UP(`FAST_ACCESS_NS);
    localparam int OFF_CYC   = `NS_TO_CYC_UP(`FAST_OFF_NS);
    localparam int WPUL_CYC  = `NS_TO_CYC_UP(`FAST_WPULSE_NS);
    localparam int WSET_CYC  = `NS_TO_CYC_UP(`FAST_WSETUP_NS);
    // write fall point: after access, leaving the setup before the rise
    localparam int WFALL_CYC = (ACC_CYC > LOW_CYC - WSET_CYC) ? ACC_CYC
                                                              : LOW_CYC - WSET_CYC;
    // write low span: the longer of the setup before the rise and the pulse
    localparam int WLOW_CYC  = (WSET_CYC > WPUL_CYC) ? WSET_CYC : WPUL_CYC;
    localparam int RMW_LOW   = (WFALL_CYC + WLOW_CYC > LOW_CYC) ? WFALL_CYC + WLOW_CYC
                                                                : LOW_CYC;

    //======================================================================
    // state
    edge_ram_pkg::ctl_state_t state;
    edge_ram_pkg::ctl_state_t next_state;
    edge_ram_pkg::ram_req_t   req;
    edge_ram_pkg::ram_pins_t  next_pins;
    logic                     timer_load;
    logic [`CNT_WIDTH-1:0]    timer_count;
    logic                     timer_done;
    logic                     read_data;

    phase_timer #(
        .WIDTH (`CNT_WIDTH)
    ) u_timer (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_load    (timer_load),
        .i_count   (timer_count),
        .o_done    (timer_done)
    );

    //======================================================================
    // decode of request kind
    wire logic is_read  = (req.kind == `KIND_READ);
    wire logic is_early = (req.kind == `KIND_EARLY_WRITE);
    wire logic is_rmw   = (req.kind == `KIND_RMW);
    wire logic take     = (state == edge_ram_pkg::ST_IDLE) && i_req_valid;
    // sample point for read data, after access time
    wire logic sample   = timer_done && (state == edge_ram_pkg::ST_LOW)
                          && !is_early;

    // next state selection
    always_comb begin
        next_state  = state;
        timer_load  = 1'b0;
        timer_count = '0;
        case (state)
            edge_ram_pkg::ST_IDLE: begin
                if (i_req_valid) begin
                    next_state  = edge_ram_pkg::ST_LOW;
                    timer_load  = 1'b1;
                    timer_count = `CNT_WIDTH'(i_req.kind == `KIND_EARLY_WRITE
                                  ? LOW_CYC : ACC_CYC);
                end
            end
            edge_ram_pkg::ST_LOW: begin
                if (timer_done) begin
                    timer_load = 1'b1;
                    if (is_rmw) begin
                        next_state  = edge_ram_pkg::ST_WRITE;
                        timer_count = `CNT_WIDTH'(WFALL_CYC - ACC_CYC);
                    end else if (is_read) begin
                        next_state  = edge_ram_pkg::ST_HOLD;
                        timer_count = `CNT_WIDTH'(LOW_CYC - ACC_CYC);
                    end else begin
                        next_state  = edge_ram_pkg::ST_HIGH;
                        timer_count = `CNT_WIDTH'(HIGH_CYC);
                    end
                end
            end
            edge_ram_pkg::ST_WRITE: begin
                if (timer_done) begin
                    next_state  = edge_ram_pkg::ST_HOLD;
                    timer_load  = 1'b1;
                    timer_count = `CNT_WIDTH'(RMW_LOW - WFALL_CYC);
                end
            end
            edge_ram_pkg::ST_HOLD: begin
                if (timer_done) begin
                    next_state  = edge_ram_pkg::ST_HIGH;
                    timer_load  = 1'b1;
                    timer_count = `CNT_WIDTH'(HIGH_CYC > OFF_CYC ? HIGH_CYC
                                                                 : OFF_CYC);
                end
            end
            edge_ram_pkg::ST_HIGH: begin
                if (timer_done) begin
                    next_state = edge_ram_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = edge_ram_pkg::ST_IDLE;
            end
        endcase
    end

    // pin values per state
    always_comb begin
        next_pins         = o_pins;
        next_pins.cycle_n = 1'b1;
        case (next_state)
            edge_ram_pkg::ST_LOW: begin
                next_pins.cycle_n = 1'b0;
                next_pins.write_n = ~is_early;
                if (take) begin
                    next_pins.addr    = i_req.addr;
                    next_pins.din     = i_req.wdata;
                    next_pins.write_n = (i_req.kind != `KIND_EARLY_WRITE);
                end
            end
            edge_ram_pkg::ST_WRITE: begin
                next_pins.cycle_n = 1'b0;
                next_pins.write_n = 1'b1;
            end
            edge_ram_pkg::ST_HOLD: begin
                next_pins.cycle_n = 1'b0;
                if (is_rmw) begin
                    next_pins.write_n = 1'b0;
                    next_pins.din     = req.invert ? ~read_data : req.wdata;
                end
            end
            edge_ram_pkg::ST_HIGH: begin
                next_pins.cycle_n = 1'b1;
                next_pins.write_n = 1'b1;
            end
            default: begin
                next_pins.cycle_n = 1'b1;
                next_pins.write_n = 1'b1;
            end
        endcase
    end

    //======================================================================
    // state and request registers
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= edge_ram_pkg::ST_IDLE;
            req   <= '0;
        end else begin
            state <= next_state;
            if (take) req <= i_req;
        end
    end

    // pin registers, strobes idle high
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pins    <= '{cycle_n: 1'b1, write_n: 1'b1, addr: '0, din: 1'b0};
            o_variant <= 1'b0;
        end else begin
            o_pins    <= next_pins;
            o_variant <= VARIANT_HIGH;
        end
    end

    // read capture and handshake outputs
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            read_data   <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_data  <= 1'b0;
            o_req_ready <= 1'b0;
        end else begin
            if (sample) read_data <= i_ram_q;
            o_rsp_valid <= sample;
            o_rsp_data  <= sample ? i_ram_q : o_rsp_data;
            o_req_ready <= (next_state == edge_ram_pkg::ST_IDLE);
        end
    end

endmodule : edge_ram_host

`default_nettype wire

// [core/edge_ram_consts.svh]
`ifndef EDGE_RAM_CONSTS_SVH
`define EDGE_RAM_CONSTS_SVH

// clock period in picoseconds (125 MHz)
`define CLOCK_PERIOD_PS   8000
// address width of the 2048 x 1 memory
`define ADDR_WIDTH        11
// fast grade strobe timing, ns
`define FAST_LOW_NS       300
`define FAST_HIGH_NS      120
`define FAST_CYCLE_NS     420
`define FAST_ACCESS_NS    300
`define FAST_OFF_NS       100
`define FAST_WPULSE_NS    80
`define FAST_WSETUP_NS    200
// slow grade strobe timing, ns
`define SLOW_LOW_NS       350
`define SLOW_HIGH_NS      150
`define SLOW_CYCLE_NS     500
// least times round up to whole cycles
`define NS_TO_CYC_UP(ns)  (((ns) * 1000 + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)
// counter width for strobe phases
`define CNT_WIDTH         7
// cycle kind codes on the command port
`define KIND_READ         2'h0
`define KIND_EARLY_WRITE  2'h1
`define KIND_RMW          2'h2

`endif

// [core/edge_ram_pkg.sv]
package edge_ram_pkg;

    // one request to the memory
    typedef struct packed {
        logic [1:0]  kind;
        logic [10:0] addr;
        logic        wdata;
        logic        invert;
    } ram_req_t;

    // the memory pins driven by the controller
    typedef struct packed {
        logic        cycle_n;
        logic        write_n;
        logic [10:0] addr;
        logic        din;
    } ram_pins_t;

    // controller sequence states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOW,
        ST_WRITE,
        ST_HOLD,
        ST_HIGH
    } ctl_state_t;

endpackage : edge_ram_pkg

// [core/phase_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "edge_ram_consts.svh"

// down counter that flags when a loaded phase length has elapsed
module phase_timer #(
    parameter int WIDTH = `CNT_WIDTH
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    // load
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_count,
    // status
    output logic                  o_done
);

    logic [WIDTH-1:0] count;

    // load or count toward zero
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= '0;
        end else if (i_load) begin
            count <= i_count;
        end else if (count != '0) begin
            count <= count - WIDTH'(1);
        end
    end

    // done from the count alone, so a load taken on done cannot loop back
    assign o_done = (count == '0);

endmodule : phase_timer

`default_nettype wire

// [test/edge_ram_host_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "edge_ram_consts.svh"
//==========================================================================
// strobe and response checks on the host ports
module edge_ram_host_chk #(
    parameter bit SLOW_GRADE   = 1'b0,
    parameter bit VARIANT_HIGH = 1'b1
) (
    input wire logic                    i_clock,
    input wire logic                    i_reset_n,
    input wire logic                    i_req_valid,
    input wire edge_ram_pkg::ram_req_t  i_req,
    input wire logic                    o_req_ready,
    input wire logic                    o_rsp_valid,
    input wire logic                    o_rsp_data,
    input wire edge_ram_pkg::ram_pins_t o_pins,
    input wire logic                    o_variant,
    input wire logic                    i_ram_q
);
    localparam int LOW_MIN  = SLOW_GRADE ? `NS_TO_CYC_UP(`SLOW_LOW_NS)
                                         : `NS_TO_CYC_UP(`FAST_LOW_NS);
    localparam int HIGH_MIN = SLOW_GRADE ? `NS_TO_CYC_UP(`SLOW_HIGH_NS)
                                         : `NS_TO_CYC_UP(`FAST_HIGH_NS);
    localparam int CYC_MIN  = SLOW_GRADE ? `NS_TO_CYC_UP(`SLOW_CYCLE_NS)
                                         : `NS_TO_CYC_UP(`FAST_CYCLE_NS);
    localparam int ACC_MIN  = `NS_TO_CYC_UP(`FAST_ACCESS_NS);
    localparam int WSET_MIN = `NS_TO_CYC_UP(`FAST_WSETUP_NS);
    logic [7:0]  cyc_cnt;
    logic        cyc_prev;
    logic [7:0]  low_cnt;
    logic [7:0]  high_cnt;
    logic [7:0]  wlow_cnt;
    logic [10:0] req_addr;
    logic [1:0]  req_kind;
    logic        req_wdata;
    // phase lengths in clocks and the last taken request
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cyc_cnt  <= 8'hff;
            cyc_prev <= 1'b1;
            low_cnt  <= 8'h00;
            high_cnt <= 8'hff;
            wlow_cnt <= 8'h00;
            req_addr <= 11'h000;
            req_kind <= 2'h0;
            req_wdata <= 1'b0;
        end else begin
            cyc_prev <= o_pins.cycle_n;
            cyc_cnt  <= (cyc_prev && !o_pins.cycle_n) ? 8'h01
                                                     : cyc_cnt + 8'(cyc_cnt != 8'hff);
            low_cnt  <= o_pins.cycle_n ? 8'h00 : low_cnt + 8'h01;
            high_cnt <= !o_pins.cycle_n ? 8'h00 : high_cnt + 8'(high_cnt != 8'hff);
            wlow_cnt <= (o_pins.cycle_n || o_pins.write_n) ? 8'h00 : wlow_cnt + 8'h01;
            if (i_req_valid && o_req_ready) begin
                req_addr  <= i_req.addr;
                req_kind  <= i_req.kind;
                req_wdata <= i_req.wdata;
            end
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    sequence s_take;
        i_req_valid && o_req_ready;
    endsequence
    sequence s_read_fall;
        $fell(o_pins.cycle_n) && o_pins.write_n;
    endsequence
    variant_tied_a: assert property ($past(i_reset_n) |-> o_variant == VARIANT_HIGH)
        else $error("variant select not at its tied level");
    low_width_a: assert property ($rose(o_pins.cycle_n) |-> low_cnt >= LOW_MIN)
        else $error("cycle strobe low phase too short");
    high_width_a: assert property ($fell(o_pins.cycle_n) |-> high_cnt >= HIGH_MIN)
        else $error("cycle strobe high phase too short");
    cycle_time_a: assert property ($fell(o_pins.cycle_n) |-> cyc_cnt >= CYC_MIN)
        else $error("full strobe cycle too short");
    late_write_a: assert property ($rose(o_pins.cycle_n) && !$past(o_pins.write_n)
        |-> wlow_cnt >= WSET_MIN) else $error("write strobe low too late");
    read_hold_a: assert property ($fell(o_pins.write_n) && !$past(o_pins.cycle_n)
        |-> low_cnt >= ACC_MIN) else $error("write strobe fell before data valid");
    take_start_a: assert property (s_take |-> ##[1:2] $fell(o_pins.cycle_n))
        else $error("taken request did not start a cycle");
    fall_pins_a: assert property ($fell(o_pins.cycle_n) |-> (o_pins.addr == req_addr)
        && (o_pins.write_n == (req_kind != `KIND_EARLY_WRITE))
        && (o_pins.write_n || o_pins.din == req_wdata)) else $error("wrong pins at fall");
    rsp_time_a: assert property (s_read_fall |-> ##[38:41] o_rsp_valid)
        else $error("read response not at access time");
    rsp_data_a: assert property (o_rsp_valid |-> o_rsp_data == $past(i_ram_q))
        else $error("response bit differs from memory output");
endmodule : edge_ram_host_chk
bind edge_ram_host edge_ram_host_chk #(.SLOW_GRADE(SLOW_GRADE), .VARIANT_HIGH(VARIANT_HIGH)) u_chk (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .o_pins(o_pins), .o_variant(o_variant), .i_ram_q(i_ram_q));
`default_nettype wire

// [test/ram_model.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// behavioural latched 2048 x 1 memory
module ram_model #(
    parameter int ACC_NS = 290,
    parameter int OFF_NS = 100
) (
    input  wire logic        cycle_n,
    input  wire logic        write_n,
    input  wire logic [10:0] addr,
    input  wire logic        din,
    output logic             q
);
    logic        mem [0:2047]; // static words, no refresh
    logic [10:0] a_lat;
    logic        w_lat;
    logic        d_lat;
    initial q = 1'b0;
    // fall latches address, write level and data; wrong bit until access
    always @(negedge cycle_n) begin
        #1; // host moves address and data on the strobe's own clock edge
        a_lat = addr;
        w_lat = write_n;
        d_lat = din;
        q = w_lat ? ~mem[a_lat] : ~q;
        #(ACC_NS - 1);
        if (!cycle_n && w_lat === 1'b1) q = mem[a_lat];
    end
    // write fall latches data and itself, later input changes ignored
    always @(negedge write_n) begin
        #1; // data moves on the same clock edge as the write strobe
        if (!cycle_n && w_lat === 1'b1) begin
            d_lat = din;
            w_lat = 1'b0;
        end
    end
    // rise commits the write, output released soon after
    always @(posedge cycle_n) begin
        if (w_lat === 1'b0) mem[a_lat] = d_lat;
        #(OFF_NS);
        q = ~q;
    end
endmodule : ram_model
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "edge_ram_consts.svh"
//==========================================================================
// host bench
module testbench;
    logic                    i_clock;
    logic                    i_reset_n;
    logic                    req_valid;
    logic                    ram_q;
    logic                    req_ready;
    logic                    rsp_valid;
    logic                    rsp_data;
    logic                    variant;
    edge_ram_pkg::ram_req_t  req;
    edge_ram_pkg::ram_pins_t pins;
    logic                    shadow [0:2047];
    int                      bad_count;
    int                      checks_done;
    // 125 MHz clock
    always #4 i_clock = ~i_clock;
    edge_ram_host #(.SLOW_GRADE(1'b0), .VARIANT_HIGH(1'b1)) DUT (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_req_valid(req_valid), .i_req(req),
        .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
        .o_pins(pins), .o_variant(variant), .i_ram_q(ram_q));
    ram_model #(.ACC_NS(`FAST_ACCESS_NS), .OFF_NS(`FAST_OFF_NS)) memory (
        .cycle_n(pins.cycle_n), .write_n(pins.write_n),
        .addr(pins.addr), .din(pins.din), .q(ram_q));
    task automatic check(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check
    // one request, waits for ready and for the read bit where there is one
    task automatic op(input logic [1:0] kind, input logic [10:0] a, input logic d, input logic inv);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge i_clock);
            n++;
        end
        check(req_ready, 1'b1, "never ready");
        req_valid = 1'b1;
        req = {kind, a, d, inv};
        @(negedge i_clock);
        req_valid = 1'b0;
        n = 0;
        if (kind != `KIND_EARLY_WRITE) begin
            while (rsp_valid !== 1'b1 && n < 100) begin
                @(negedge i_clock);
                n++;
            end
            check(rsp_valid, 1'b1, "no response");
            check(rsp_data, shadow[a], "read bit");
        end
        if (kind != `KIND_READ) shadow[a] = (kind == `KIND_RMW && inv) ? ~shadow[a] : d;
    endtask : op
    task automatic reset_idle();
        repeat (10) @(negedge i_clock);
        check(pins.cycle_n, 1'b1, "strobe active in reset");
        check(pins.write_n, 1'b1, "write active in reset");
        check(req_ready, 1'b0, "ready in reset");
        i_reset_n = 1'b1;
        repeat (2) @(negedge i_clock);
        check(variant, 1'b1, "variant level");
    endtask : reset_idle
    // early writes at the address ends and neighbours, then read back
    task automatic write_read();
        logic [10:0] a [4] = '{11'h000, 11'h7ff, 11'h555, 11'h554};
        logic [3:0]  d = 4'h9;
        for (int i = 0; i < 4; i++) op(`KIND_EARLY_WRITE, a[i], d[i], 1'b0);
        for (int i = 0; i < 4; i++) op(`KIND_READ, a[i], 1'b0, 1'b0);
    endtask : write_read
    // back-to-back read-modify-writes, inverting and plain
    task automatic modify();
        op(`KIND_RMW, 11'h555, 1'b0, 1'b1);
        op(`KIND_READ, 11'h555, 1'b0, 1'b0);
        op(`KIND_RMW, 11'h7ff, 1'b1, 1'b0);
        op(`KIND_RMW, 11'h7ff, 1'b0, 1'b1);
        op(`KIND_READ, 11'h7ff, 1'b0, 1'b0);
        op(`KIND_READ, 11'h554, 1'b0, 1'b0);
    endtask : modify
    task automatic results();
        $display("mismatches %0d, checks %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    initial begin
        i_clock = 1'b0;
        i_reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        bad_count = 0;
        checks_done = 0;
        reset_idle();
        write_read();
        modify();
        results();
    end
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge i_clock);
        bad_count++;
        results();
    end
endmodule : testbench
`default_nettype wire
